// ===== hdl/vear_pkg.sv
// Purpose: shared constants and carriers for the encoder auxiliary control register bank
// Assumes: byte-wide register port behind the two-wire serial engine, 100 MHz clk_sys
// Notes: offsets are register indices as seen by the serial engine
package vear_pkg;

	// register indices
	localparam logic [7:0] IDX_ANC_CTRL = 8'h06;
	localparam logic [7:0] IDX_MATCH_ID = 8'h07;
	localparam logic [7:0] IDX_FREQ3 = 8'h08;
	localparam logic [7:0] IDX_FREQ2 = 8'h09;
	localparam logic [7:0] IDX_FREQ1 = 8'h0A;
	localparam logic [7:0] IDX_FREQ0 = 8'h0B;
	localparam logic [7:0] IDX_PHASE_HI = 8'h0C;
	localparam logic [7:0] IDX_PHASE_LO = 8'h0D;
	localparam logic [7:0] IDX_PORT_DATA = 8'h0E;
	localparam logic [7:0] IDX_PORT_DIR = 8'h0F;

	// ancillary control register fields
	localparam int CTRL_TIMING_BIT = 0;
	localparam int CTRL_PHASE_BIT = 1;
	localparam int CTRL_FREQ_BIT = 2;
	localparam int CTRL_FIELD_LSB = 3;
	localparam int CTRL_LOCK_BIT = 6;

	// reset values
	localparam logic [31:0] FREQ_RESET = 32'h43E0F83E;
	localparam logic [15:0] PHASE_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [2:0] FIELD_RESET = 3'h0;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// pins shared with alternate functions: 7 and 6 inputs, 1 and 0 outputs
	localparam logic [7:0] ALT_IN_PINS = 8'hC0;
	localparam logic [7:0] ALT_OUT_PINS = 8'h03;

	// host access from the serial engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] index;
		logic [7:0] wdata;
	} vear_host_t;

	// one received ancillary packet, presented for one cycle
	typedef struct packed {
		logic valid;
		logic [7:0] data_id;
		logic freq_valid_bit;
		logic phase_valid_bit;
		logic sync_valid_flag;
		logic [2:0] field;
		logic [31:0] freq;
		logic [15:0] phase;
	} vear_anc_t;

endpackage

// ===== hdl/vear_regs.sv
// Purpose: ancillary control, match id, subcarrier frequency/phase and general purpose port
// Assumes: serial engine presents byte accesses as one-cycle strobes; pin inputs asynchronous
// Notes: every output is registered; read data appears one cycle after the read strobe
//
// Overview of operation
// - lock flag reads 0 when the synthesizer is locked to the reference.
// - read-only 3-bit field number, 000 first field through 111 eighth.
// - frequency load enable set: valid ancillary frequency loads the word; else host only.
// - genlock enabled: genlock circuit drives frequency; host keeps frequency load off.
// - phase load enable set: valid ancillary phase used; else phase is zero.
// - genlock enabled: genlock circuit drives phase; host keeps phase load off.
// - timing enable set: ancillary field and sync-valid used; else ignored.
// - upper seven match id bits compared with packet id; only matches accepted.
// - match id bit 0 is stored parity, never used in matching.
// - 32-bit frequency word over four bytes, MSB at 08h, LSB at 0Bh.
// - upper three frequency bytes buffered, committed together on LSB write.
// - 16-bit static phase offset held in two registers, nominal zero.
// - port data bit n maps pin n; reads give pin state for inputs, written value for outputs; writes set output.
// - pins 7, 6, 1, 0 multiplexed with alternate signals.
// - direction bit 0 makes pin input, 1 makes it output from data register.
// - lock flag read-only, meaningful with genlock, reads 1 before lock.
// - genlock enable locks internal synthesizer to external reference.
module vear_regs #(
	parameter int PINS = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// register port from the serial engine
	input wire vear_pkg::vear_host_t host,
	output logic [7:0] reg_rdata,
	// genlock
	input wire logic genlock_enable,
	input wire logic synth_locked,
	input wire logic [31:0] genlock_freq,
	input wire logic [15:0] genlock_phase,
	output logic synth_lock_req,
	output logic lock_fail_flag,
	// timing and ancillary stream
	input wire logic field_tick,
	input wire vear_pkg::vear_anc_t anc,
	output logic [2:0] field_number,
	output logic anc_timing_strobe,
	output logic sync_valid_flag,
	// subcarrier
	output logic [31:0] subcarrier_increment,
	output logic [15:0] subcarrier_phase,
	output logic [15:0] phase_offset_value,
	// general purpose port
	input wire logic [PINS-1:0] pin_in,
	input wire logic [PINS-1:0] alt_sel,
	input wire logic [PINS-1:0] alt_out,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	output logic [PINS-1:0] alt_in
);

	logic [2:0] ctrl_en_r;
	logic [7:0] match_id_r;
	logic [23:0] freq_shadow_r;
	logic [31:0] freq_r;
	logic [15:0] phase_offset_r;
	logic [15:0] anc_phase_r;
	logic [2:0] field_r;
	logic lock_fail_r;
	logic [PINS-1:0] port_data_bits_r;
	logic [PINS-1:0] port_direction_bits_r;
	logic [PINS-1:0] pin_meta_r;
	logic [PINS-1:0] pin_sync_r;
	logic [PINS-1:0] port_read;
	logic id_match;
	logic wr_ctrl;
	logic wr_freq0;

	// decoded register strobes and gated ancillary loads
	logic wr_match_id;
	logic wr_freq3;
	logic wr_freq2;
	logic wr_freq1;
	logic wr_phase_hi;
	logic wr_phase_lo;
	logic wr_port_data;
	logic wr_port_dir;
	logic take_freq;
	logic take_phase;
	logic take_timing;
	logic [7:0] ctrl_read;

	// packet is ours only when the seven id bits agree, parity bit ignored
	assign id_match = anc.valid && (anc.data_id[7:1] == match_id_r[7:1]);

	// one write strobe per index; a single decode keeps the register map in one place
	assign wr_ctrl = host.wr && (host.index == vear_pkg::IDX_ANC_CTRL);
	assign wr_match_id = host.wr && (host.index == vear_pkg::IDX_MATCH_ID);
	assign wr_freq3 = host.wr && (host.index == vear_pkg::IDX_FREQ3);
	assign wr_freq2 = host.wr && (host.index == vear_pkg::IDX_FREQ2);
	assign wr_freq1 = host.wr && (host.index == vear_pkg::IDX_FREQ1);
	assign wr_freq0 = host.wr && (host.index == vear_pkg::IDX_FREQ0);
	assign wr_phase_hi = host.wr && (host.index == vear_pkg::IDX_PHASE_HI);
	assign wr_phase_lo = host.wr && (host.index == vear_pkg::IDX_PHASE_LO);
	assign wr_port_data = host.wr && (host.index == vear_pkg::IDX_PORT_DATA);
	assign wr_port_dir = host.wr && (host.index == vear_pkg::IDX_PORT_DIR);

	// ancillary loads, each gated by its enable and the id match; frequency and phase also by the packet's own valid bit
	assign take_freq = ctrl_en_r[vear_pkg::CTRL_FREQ_BIT] && id_match && anc.freq_valid_bit;
	assign take_phase = ctrl_en_r[vear_pkg::CTRL_PHASE_BIT] && id_match && anc.phase_valid_bit;
	assign take_timing = ctrl_en_r[vear_pkg::CTRL_TIMING_BIT] && id_match;

	// writable enables of the control register; status bits are not stored here
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_en_r <= 3'h0;
		end else if (wr_ctrl) begin
			ctrl_en_r <= host.wdata[vear_pkg::CTRL_FREQ_BIT:vear_pkg::CTRL_TIMING_BIT];
		end
	end

	// match id register, parity stored as written
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			match_id_r <= vear_pkg::BYTE_RESET;
		end else if (wr_match_id) begin
			match_id_r <= host.wdata;
		end
	end

	// upper frequency bytes only reach the shadow
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			freq_shadow_r <= vear_pkg::FREQ_RESET[31:8];
		end else if (wr_freq3) begin
			freq_shadow_r[23:16] <= host.wdata;
		end else if (wr_freq2) begin
			freq_shadow_r[15:8] <= host.wdata;
		end else if (wr_freq1) begin
			freq_shadow_r[7:0] <= host.wdata;
		end
	end

	// active frequency word; a matching ancillary load wins over a host commit
	// in the same cycle since the stream is the newer source
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			freq_r <= vear_pkg::FREQ_RESET;
		end else if (take_freq) begin
			freq_r <= anc.freq;
		end else if (wr_freq0) begin
			freq_r <= {freq_shadow_r, host.wdata};
		end
	end

	// static phase offset, two host bytes
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			phase_offset_r <= vear_pkg::PHASE_RESET;
		end else if (wr_phase_hi) begin
			phase_offset_r[15:8] <= host.wdata;
		end else if (wr_phase_lo) begin
			phase_offset_r[7:0] <= host.wdata;
		end
	end

	// phase captured from matching packets with the phase-valid bit
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			anc_phase_r <= vear_pkg::PHASE_RESET;
		end else if (take_phase) begin
			anc_phase_r <= anc.phase;
		end
	end

	// synthesizer lock request follows the genlock enable
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			synth_lock_req <= 1'b0;
		end else begin
			synth_lock_req <= genlock_enable;
		end
	end

	// static offset handed on to the phase path
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			phase_offset_value <= vear_pkg::PHASE_RESET;
		end else begin
			phase_offset_value <= phase_offset_r;
		end
	end

	// subcarrier drive: genlock overrides, firmware is trusted to clear the load enables
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			subcarrier_increment <= vear_pkg::FREQ_RESET;
			subcarrier_phase <= vear_pkg::PHASE_RESET;
		end else begin
			if (genlock_enable) begin
				subcarrier_increment <= genlock_freq;
				subcarrier_phase <= genlock_phase;
			end else begin
				subcarrier_increment <= freq_r;
				subcarrier_phase <= ctrl_en_r[vear_pkg::CTRL_PHASE_BIT] ?
					anc_phase_r : vear_pkg::PHASE_RESET;
			end
		end
	end

	// lock status: 0 once locked, 1 while still hunting
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lock_fail_r <= 1'b1;
		end else begin
			lock_fail_r <= !synth_locked;
		end
	end
	assign lock_fail_flag = lock_fail_r;

	// field counter wraps after the eighth field; stream timing reloads it when enabled
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			field_r <= vear_pkg::FIELD_RESET;
		end else if (take_timing && anc.sync_valid_flag) begin
			field_r <= anc.field;
		end else if (field_tick) begin
			field_r <= field_r + 3'h1;
		end
	end
	assign field_number = field_r;

	// timing reference handed on only when enabled, otherwise dropped
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			anc_timing_strobe <= 1'b0;
			sync_valid_flag <= 1'b0;
		end else begin
			anc_timing_strobe <= take_timing;
			sync_valid_flag <= take_timing && anc.sync_valid_flag;
		end
	end

	// port data register, written value drives output pins
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			port_data_bits_r <= '0;
		end else if (wr_port_data) begin
			port_data_bits_r <= host.wdata[PINS-1:0];
		end
	end

	// port direction register; reset leaves every pin an input
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			port_direction_bits_r <= '0;
		end else if (wr_port_dir) begin
			port_direction_bits_r <= host.wdata[PINS-1:0];
		end
	end

	// two-stage pin synchroniser; only the second stage is looked at
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// pin drive: alternate outputs on pins 1 and 0 take the pin when selected
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_out <= '0;
			pin_oe <= '0;
		end else begin
			for (int i = 0; i < PINS; i++) begin
				if (vear_pkg::ALT_OUT_PINS[i] && alt_sel[i]) begin
					pin_out[i] <= alt_out[i];
					pin_oe[i] <= 1'b1;
				end else begin
					pin_out[i] <= port_data_bits_r[i];
					pin_oe[i] <= port_direction_bits_r[i];
				end
			end
		end
	end

	// pins 7 and 6 feed their alternate input whatever the direction
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			alt_in <= '0;
		end else begin
			for (int i = 0; i < PINS; i++) begin
				alt_in[i] <= vear_pkg::ALT_IN_PINS[i] && alt_sel[i] && pin_sync_r[i];
			end
		end
	end

	// inputs read the pin, outputs read back the written value
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			port_read[i] = port_direction_bits_r[i] ? port_data_bits_r[i] : pin_sync_r[i];
		end
	end

	// status view of the control register; reserved bit 7 always reads 0
	always_comb begin
		ctrl_read = vear_pkg::BYTE_RESET;
		ctrl_read[vear_pkg::CTRL_LOCK_BIT] = lock_fail_r;
		ctrl_read[vear_pkg::CTRL_FIELD_LSB +: 3] = field_r;
		ctrl_read[vear_pkg::CTRL_FREQ_BIT:vear_pkg::CTRL_TIMING_BIT] = ctrl_en_r;
	end

	// read mux, registered; unmapped indices read zero
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= vear_pkg::READ_UNMAPPED;
		end else if (host.rd) begin
			if (host.index == vear_pkg::IDX_ANC_CTRL) begin
				reg_rdata <= ctrl_read;
			end else if (host.index == vear_pkg::IDX_MATCH_ID) begin
				reg_rdata <= match_id_r;
			end else if (host.index == vear_pkg::IDX_FREQ3) begin
				reg_rdata <= freq_r[31:24];
			end else if (host.index == vear_pkg::IDX_FREQ2) begin
				reg_rdata <= freq_r[23:16];
			end else if (host.index == vear_pkg::IDX_FREQ1) begin
				reg_rdata <= freq_r[15:8];
			end else if (host.index == vear_pkg::IDX_FREQ0) begin
				reg_rdata <= freq_r[7:0];
			end else if (host.index == vear_pkg::IDX_PHASE_HI) begin
				reg_rdata <= phase_offset_r[15:8];
			end else if (host.index == vear_pkg::IDX_PHASE_LO) begin
				reg_rdata <= phase_offset_r[7:0];
			end else if (host.index == vear_pkg::IDX_PORT_DATA) begin
				reg_rdata <= 8'(port_read);
			end else if (host.index == vear_pkg::IDX_PORT_DIR) begin
				reg_rdata <= 8'(port_direction_bits_r);
			end else begin
				reg_rdata <= vear_pkg::READ_UNMAPPED;
			end
		end
	end

endmodule

// ===== verification/tb.sv
// Purpose: register-level tests of the aux control bank
// Assumes: inputs change on the falling edge
// Notes: expectations come from the register map
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	vear_pkg::vear_host_t host;
	vear_pkg::vear_anc_t anc = '0;
	logic gl_en = 1'b0;
	logic locked = 1'b0;
	logic tick = 1'b0;
	logic [7:0] pin_in = 8'h00;
	logic [7:0] alt_sel = 8'h00;
	logic [7:0] alt_out = 8'h00;
	logic [7:0] rdata, pin_out, pin_oe, alt_in;
	logic [2:0] fld;
	logic req, lockf, strb, svf;
	logic [31:0] inc;
	logic [15:0] ph, ofs;
	int n_mismatch = 0;
	int checked = 0;
	int cyc = 0;
	int n_strb = 0;
	int n_svf = 0;
	logic [7:0] rv [11] = '{8'h40, 8'h00, 8'h43, 8'hE0, 8'hF8, 8'h3E, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};
	always #5 clk_sys = ~clk_sys;
	vear_regs uut (.clk_sys(clk_sys), .rstn(rstn), .host(host), .reg_rdata(rdata),
		.genlock_enable(gl_en), .synth_locked(locked), .genlock_freq(32'hCAFE0123),
		.genlock_phase(16'h5A5A), .synth_lock_req(req), .lock_fail_flag(lockf),
		.field_tick(tick), .anc(anc), .field_number(fld), .anc_timing_strobe(strb),
		.sync_valid_flag(svf), .subcarrier_increment(inc), .subcarrier_phase(ph),
		.phase_offset_value(ofs), .pin_in(pin_in), .alt_sel(alt_sel),
		.alt_out(alt_out), .pin_out(pin_out), .pin_oe(pin_oe), .alt_in(alt_in));
	vear_host_model u_host (.clk_sys(clk_sys), .host(host), .reg_rdata(rdata));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] i, input logic [7:0] exp);
		logic [7:0] q;
		u_host.rd(i, q);
		chk(q, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// one packet; contents scrambled once valid drops
	task automatic send(input logic [7:0] id, input logic [31:0] f, input logic [2:0] fl);
		@(negedge clk_sys);
		anc = '{1'b1, id, 1'b1, 1'b1, 1'b1, fl, f, f[15:0]};
		@(negedge clk_sys);
		anc = '{1'b0, ~id, 1'b0, 1'b0, 1'b0, ~fl, ~f, ~f[15:0]};
		idle(3);
	endtask
	task automatic test_done;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// hang guard, far above the run length
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			test_done;
		end
	end
	// one-cycle pulses are counted here; strobes compared after each packet, sync-valid flags after the first and third
	always @(negedge clk_sys) begin
		if (strb === 1'b1)
			n_strb++;
		if (svf === 1'b1)
			n_svf++;
	end
	initial begin
		idle(10);
		rstn = 1'b1;
		for (int i = 0; i < 11; i++)
			rchk(8'h06 + 8'(i), rv[i]);
		chk(lockf, 1'b1);
		u_host.wr(8'h08, 8'h12);
		u_host.wr(8'h09, 8'h34);
		u_host.wr(8'h0A, 8'h56);
		rchk(8'h08, 8'h43);
		chk(inc, 32'h43E0F83E);
		u_host.wr(8'h0B, 8'h78);
		idle(2);
		chk(inc, 32'h12345678);
		rchk(8'h0B, 8'h78);
		u_host.wr(8'h0C, 8'hAB);
		u_host.wr(8'h0D, 8'hCD);
		idle(2);
		chk(ofs, 16'hABCD);
		rchk(8'h0D, 8'hCD);
		pin_in = 8'h42;
		alt_sel = 8'h41;
		alt_out = 8'h01;
		u_host.wr(8'h0F, 8'h3C);
		u_host.wr(8'h0E, 8'hA5);
		idle(3);
		rchk(8'h0E, 8'h66);
		rchk(8'h0F, 8'h3C);
		chk(pin_oe, 8'h3D);
		chk(pin_out & 8'h3D, 8'h25);
		chk(alt_in & 8'hC0, 8'h40);
		locked = 1'b1;
		repeat (3) begin
			tick = 1'b1;
			idle(1);
			tick = 1'b0;
			idle(1);
		end
		chk(lockf, 1'b0);
		u_host.wr(8'h06, 8'hFF);
		rchk(8'h06, 8'h1F);
		u_host.wr(8'h07, 8'h41);
		rchk(8'h07, 8'h41);
		send(8'h40, 32'h0BADF00D, 3'h5);
		chk(inc, 32'h0BADF00D);
		chk(ph, 16'hF00D);
		chk(fld, 3'h5);
		chk(n_strb, 1);
		chk(n_svf, 1);
		send(8'h42, 32'h11111111, 3'h1);
		chk(inc, 32'h0BADF00D);
		chk(n_strb, 1);
		u_host.wr(8'h06, 8'h00);
		send(8'h40, 32'h33333333, 3'h2);
		chk(inc, 32'h0BADF00D);
		chk(ph, 16'h0000);
		chk(fld, 3'h5);
		chk(n_strb, 1);
		chk(n_svf, 1);
		gl_en = 1'b1;
		idle(3);
		chk(inc, 32'hCAFE0123);
		chk(ph, 16'h5A5A);
		chk(req, 1'b1);
		test_done;
	end
endmodule

// ===== verification/vear_host_model.sv
// Purpose: host model making indexed register accesses
// Assumes: one-cycle strobes launched on the falling edge
// Notes: index scrambled once a strobe drops
module vear_host_model (
	// clock
	input wire logic clk_sys,
	// register port
	output vear_pkg::vear_host_t host,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial host = '0;
	// write by index
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		@(negedge clk_sys);
		host = '{wr: 1'b1, rd: 1'b0, index: i, wdata: d};
		@(negedge clk_sys);
		host = '{wr: 1'b0, rd: 1'b0, index: ~i, wdata: ~d};
	endtask
	// read by index, data taken after the edge
	task automatic rd(input logic [7:0] i, output logic [7:0] q);
		@(negedge clk_sys);
		host = '{wr: 1'b0, rd: 1'b1, index: i, wdata: 8'h00};
		@(negedge clk_sys);
		host = '{wr: 1'b0, rd: 1'b0, index: ~i, wdata: 8'hFF};
		q = reg_rdata;
	endtask
endmodule

// ===== verification/vear_regs_assertions.sv
// Purpose: port checks for the aux control register bank
// Assumes: one clock, rstn async active low
// Notes: bound into every vear_regs instance
module vear_regs_chk #(
	parameter int PINS = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// host and genlock
	input wire vear_pkg::vear_host_t host,
	input wire logic [7:0] reg_rdata,
	input wire logic genlock_enable,
	input wire logic synth_locked,
	input wire logic synth_lock_req,
	input wire logic lock_fail_flag,
	// timing and ancillary
	input wire logic field_tick,
	input wire vear_pkg::vear_anc_t anc,
	input wire logic [2:0] field_number,
	input wire logic anc_timing_strobe,
	input wire logic sync_valid_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// keeps $past from reaching into reset
	logic up_r;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			up_r <= 1'b0;
		end else begin
			up_r <= 1'b1;
		end
	end
	chk_lock_follow: assert property (
		up_r |-> lock_fail_flag == !$past(synth_locked)) else $error("lock flag wrong");
	chk_lock_request: assert property (
		up_r |-> synth_lock_req == $past(genlock_enable)) else $error("lock request wrong");
	chk_field_step: assert property (
		field_tick && !anc.valid |=> field_number == $past(field_number) + 3'h1)
		else $error("field did not step");
	chk_ro_ignore: assert property (
		host.wr && host.index == 8'h06 && !field_tick && !anc.valid |=> $stable(field_number))
		else $error("field changed by write");
	chk_unmapped_read: assert property (
		host.rd && host.index > 8'h0F |=> reg_rdata == 8'h00) else $error("unmapped read");
	chk_rdata_hold: assert property (
		!host.rd |=> $stable(reg_rdata)) else $error("read data moved");
	chk_strobe_cause: assert property (
		anc_timing_strobe |-> $past(anc.valid)) else $error("strobe without packet");
	chk_sync_pair: assert property (
		sync_valid_flag |-> anc_timing_strobe && $past(anc.sync_valid_flag))
		else $error("sync flag unpaired");
	cover property (anc_timing_strobe);
	cover property (sync_valid_flag);
	cover property (host.wr && host.index == 8'h0B);
endmodule

bind vear_regs vear_regs_chk #(.PINS(PINS)) u_chk (.clk_sys(clk_sys), .rstn(rstn),
	.host(host), .reg_rdata(reg_rdata), .genlock_enable(genlock_enable),
	.synth_locked(synth_locked), .synth_lock_req(synth_lock_req),
	.lock_fail_flag(lock_fail_flag), .field_tick(field_tick), .anc(anc),
	.field_number(field_number), .anc_timing_strobe(anc_timing_strobe),
	.sync_valid_flag(sync_valid_flag));
